// file: verilog/rst_pkg.sv
// constants and types shared by the reset sequencer
package rst_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int          CLK_MHZ        = 50;
	localparam int          T_POWERUP_TIMER_MS      = 64;
	localparam int          T_POR_US       = 10;
	localparam int          T_RST_US       = 10;
	localparam logic [31:0] POWERUP_TIMER_CYCLES    = 32'(T_POWERUP_TIMER_MS * 1000 * CLK_MHZ);
	localparam logic [31:0] POR_CYCLES     = 32'(T_POR_US * CLK_MHZ);
	localparam logic [31:0] RST_CYCLES     = 32'(T_RST_US * CLK_MHZ);
	localparam int          OST_W          = 10;
	localparam logic [9:0]  OST_LAST       = 10'h3FF;

	// ****************************************
	// register map
	// ****************************************
	localparam int          ADDR_W         = 4;
	localparam logic [3:0]  STATUS_OFS     = 4'h0;
	localparam logic [3:0]  OSC_OFS        = 4'h1;
	localparam logic [15:0] STATUS_POR_VAL = 16'h0003;
	localparam logic [15:0] STATUS_WR_MASK = 16'hC7FF;

	// ****************************************
	// status field positions
	// ****************************************
	localparam int BIT_TRAP     = 15;
	localparam int BIT_ILLEGAL  = 14;
	localparam int BIT_DEEPSLP  = 10;
	localparam int BIT_CFGMIS   = 9;
	localparam int BIT_PROGMEM_SLEEP_POWER    = 8;
	localparam int BIT_PIN      = 7;
	localparam int BIT_SOFT     = 6;
	localparam int BIT_WDTEN    = 5;
	localparam int BIT_WATCHDOG_TIMEOUT_FLAG     = 4;
	localparam int BIT_SLEEP    = 3;
	localparam int BIT_IDLE     = 2;
	localparam int BIT_BROWNOUT = 1;
	localparam int BIT_POWERON  = 0;

	// ****************************************
	// oscillator select field
	// ****************************************
	localparam int         OSC_LSB       = 12;
	localparam int         OSC_MSB       = 14;
	localparam logic [2:0] OSC_RESET     = 3'h0;
	localparam logic [2:0] OSC_FAST_RC   = 3'h0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [0:0] {
		ST_HOLD = 1'b0,
		ST_RUN  = 1'b1
	} rst_state_t;

	typedef enum logic [1:0] {
		KIND_POR   = 2'b00,
		KIND_BOR   = 2'b01,
		KIND_OTHER = 2'b10
	} rst_kind_t;

endpackage

// file: verilog/rst_sequencer.sv
// reset cause status, clock source choice and system reset release timing
// Function
// - trap conflict sets status bit 15; cleared by power-on or software.
// - illegal opcode, address mode or uninitialised pointer sets bit 14.
// - sleep with deep-sleep armed sets bit 10; software clear only.
// - configuration mismatch reset sets bit 9; power-on clears it.
// - bit 8 keeps program memory bias powered in sleep when set.
// - master clear pin reset sets bit 7; power-on clears it.
// - reset instruction sets bit 6; power-on clears it.
// - bit 5 enables watchdog; unprogrammed fuse forces it on.
// - watchdog time-out sets bit 4; power-save or power-on clears it.
// - sleep sets bit 3, idle sets bit 2; power-on or software clears.
// - brown-out and power-on both set bit 1; hardware never clears it.
// - power-on sets bits 0 and 1; every other flag resets to zero.
// - software may set or clear flags other than bit 10 without causing any reset.
// - with switching, power-on/brown-out use fuses, others current select.
// - without switching, clock source comes from the fuses except during two-speed start-up.
// - system reset held until power-on and power-up delays expire.
// - delay per kind: por+rst+powerup_timer, rst+powerup_timer for brown-out, else rst.
// - start-up timer and pll wait run alongside; run needs both releases.
// - power-up timer is 64 ms when the regulator is disabled.
// - start-up timer is a 10-bit counter of 1024 oscillator periods.
// - clock fail monitor starts only after system reset release.
// - two-speed start-up begins on the fast rc oscillator.
// - any active reset source drives the system reset active.
`timescale 1ns/1ps

module rst_sequencer #(
	parameter logic [31:0] POWERUP_TIMER_CYCLES = rst_pkg::POWERUP_TIMER_CYCLES,
	parameter logic [31:0] POR_CYCLES  = rst_pkg::POR_CYCLES,
	parameter logic [31:0] RST_CYCLES  = rst_pkg::RST_CYCLES
) (
	// clock and power-on reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// reset sources
	input  wire logic        masterClearPin_n,
	input  wire logic        brownoutEvent,
	input  wire logic        trapConflict,
	input  wire logic        illegalOp,
	input  wire logic        cfgMismatch,
	input  wire logic        softResetInstr,
	input  wire logic        watchdogTimeout,
	// power-save instructions
	input  wire logic        sleepInstr,
	input  wire logic        idleInstr,
	input  wire logic        deepSleepArm,
	// configuration fuses and pins
	input  wire logic        watchdogFuseEnable,
	input  wire logic        clockSwitchEnable,
	input  wire logic [2:0]  cfgOscSelect,
	input  wire logic        twoSpeedStartup,
	input  wire logic        regulatorDisablePin,
	input  wire logic        clockFailMonitorFuse,
	// oscillator status
	input  wire logic        oscTick,
	input  wire logic        oscNeedsStartup,
	input  wire logic        pllEnable,
	input  wire logic        pllLocked,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdData,
	// system outputs
	output logic             systemReset_n,
	output logic             clockReleased,
	output logic             execEnable,
	output logic             watchdogEnable,
	output logic             progmemSleepPower,
	output logic             clockFailMonitorEnable,
	output logic      [2:0]  sysClkSelect
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		rst_pkg::rst_state_t state;
		rst_pkg::rst_kind_t  kind;
		logic [31:0]         delayCount;
		logic [9:0]          ostCount;
		logic                ostDone;
		logic [15:0]         status;
		logic [2:0]          currentOsc;
		logic [15:0]         rdData;
		logic                sysRstN;
		logic                clkRel;
		logic                exec;
		logic                wdtEn;
		logic                pmSleep;
		logic                monEn;
		logic [2:0]          clkSel;
	} rst_regs_t;

	rst_regs_t cur;
	rst_regs_t next_cur;

	logic        anySource;
	logic        otherSource;
	logic [31:0] pwrtLoad;
	logic [31:0] delayLoad;
	logic        powerSave;
	logic [15:0] hwSet;
	logic        oscReady;
	logic        pllReady;
	logic [2:0]  targetOsc;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_cur = cur;

		// sources other than power-on and brown-out
		otherSource = !masterClearPin_n | trapConflict | illegalOp | cfgMismatch
			| softResetInstr | watchdogTimeout;
		anySource = otherSource | brownoutEvent;

		// power-up timer only when the regulator is off
		pwrtLoad = regulatorDisablePin ? POWERUP_TIMER_CYCLES : 32'h0000_0000;
		if (brownoutEvent) begin
			delayLoad = RST_CYCLES + pwrtLoad;
		end else begin
			delayLoad = RST_CYCLES;
		end

		// ---- sequencing ----
		if (anySource) begin
			next_cur.state      = rst_pkg::ST_HOLD;
			// a short source never cuts a longer hold that is still running
			if (cur.state == rst_pkg::ST_HOLD && cur.delayCount > delayLoad) begin
				next_cur.delayCount = cur.delayCount;
			end else begin
				next_cur.delayCount = delayLoad;
			end
			next_cur.ostCount   = 10'h000;
			next_cur.ostDone    = 1'b0;
			if (brownoutEvent) begin
				next_cur.kind = rst_pkg::KIND_BOR;
			end else if (cur.kind != rst_pkg::KIND_BOR || cur.state == rst_pkg::ST_RUN) begin
				// a pin reset during a pending brown-out keeps the longer kind
				if (cur.state == rst_pkg::ST_RUN) begin
					next_cur.kind = rst_pkg::KIND_OTHER;
				end
			end
		end else begin
			case (cur.state)
				rst_pkg::ST_HOLD: begin
					if (cur.delayCount <= 32'h0000_0001) begin
						next_cur.state      = rst_pkg::ST_RUN;
						next_cur.delayCount = 32'h0000_0000;
					end else begin
						next_cur.delayCount = cur.delayCount - 32'h0000_0001;
					end
				end
				rst_pkg::ST_RUN: begin
					next_cur.delayCount = 32'h0000_0000;
				end
				default: begin
					next_cur.state = rst_pkg::ST_HOLD;
				end
			endcase
		end

		// start-up timer runs alongside the reset delay
		if (!anySource && !cur.ostDone && oscTick) begin
			if (cur.ostCount == rst_pkg::OST_LAST) begin
				next_cur.ostDone = 1'b1;
			end else begin
				next_cur.ostCount = cur.ostCount + 10'h001;
			end
		end

		// ---- clock source selection ----
		if (cur.state == rst_pkg::ST_HOLD
			&& (cur.kind == rst_pkg::KIND_POR || cur.kind == rst_pkg::KIND_BOR)) begin
			next_cur.currentOsc = cfgOscSelect;
		end
		targetOsc = clockSwitchEnable ? cur.currentOsc : cfgOscSelect;
		oscReady  = cur.ostDone | !oscNeedsStartup;
		pllReady  = pllLocked | !pllEnable;

		// two-speed start runs on the fast rc until the target is ready
		if (twoSpeedStartup && !(oscReady && pllReady)) begin
			next_cur.clkSel = rst_pkg::OSC_FAST_RC;
			next_cur.clkRel = 1'b1;
		end else begin
			next_cur.clkSel = targetOsc;
			next_cur.clkRel = oscReady & pllReady;
		end

		// ---- status flags ----
		powerSave = sleepInstr | idleInstr;
		if (regWr && regAddr == rst_pkg::STATUS_OFS) begin
			next_cur.status = regWrData & rst_pkg::STATUS_WR_MASK;
			// deep-sleep flag may only be cleared by software
			next_cur.status[rst_pkg::BIT_DEEPSLP] = cur.status[rst_pkg::BIT_DEEPSLP]
				& regWrData[rst_pkg::BIT_DEEPSLP];
		end
		if (powerSave) begin
			next_cur.status[rst_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		end

		// hardware sets applied last so they win over a write
		hwSet = 16'h0000;
		hwSet[rst_pkg::BIT_TRAP]     = trapConflict;
		hwSet[rst_pkg::BIT_ILLEGAL]  = illegalOp;
		hwSet[rst_pkg::BIT_DEEPSLP]  = sleepInstr & deepSleepArm;
		hwSet[rst_pkg::BIT_CFGMIS]   = cfgMismatch;
		hwSet[rst_pkg::BIT_PIN]      = !masterClearPin_n;
		hwSet[rst_pkg::BIT_SOFT]     = softResetInstr;
		hwSet[rst_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]     = watchdogTimeout;
		hwSet[rst_pkg::BIT_SLEEP]    = sleepInstr;
		hwSet[rst_pkg::BIT_IDLE]     = idleInstr;
		hwSet[rst_pkg::BIT_BROWNOUT] = brownoutEvent;
		next_cur.status = next_cur.status | hwSet;

		// ---- oscillator control register ----
		if (regWr && regAddr == rst_pkg::OSC_OFS && cur.state == rst_pkg::ST_RUN) begin
			next_cur.currentOsc = regWrData[rst_pkg::OSC_MSB:rst_pkg::OSC_LSB];
		end

		// ---- read port ----
		next_cur.rdData = 16'h0000;
		if (regRd) begin
			case (regAddr)
				rst_pkg::STATUS_OFS: begin
					next_cur.rdData = cur.status & rst_pkg::STATUS_WR_MASK;
				end
				rst_pkg::OSC_OFS: begin
					next_cur.rdData[rst_pkg::OSC_MSB:rst_pkg::OSC_LSB] = cur.currentOsc;
				end
				default: begin
					next_cur.rdData = 16'h0000;
				end
			endcase
		end

		// ---- outputs ----
		next_cur.sysRstN = (next_cur.state == rst_pkg::ST_RUN);
		next_cur.exec    = next_cur.sysRstN & next_cur.clkRel;
		next_cur.monEn   = clockFailMonitorFuse & next_cur.sysRstN;
		next_cur.wdtEn   = watchdogFuseEnable
			| next_cur.status[rst_pkg::BIT_WDTEN];
		next_cur.pmSleep = next_cur.status[rst_pkg::BIT_PROGMEM_SLEEP_POWER];
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur.state      <= rst_pkg::ST_HOLD;
			cur.kind       <= rst_pkg::KIND_POR;
			// power-on holds for the full sum; the regulator pin is not known yet
			cur.delayCount <= POR_CYCLES + RST_CYCLES + POWERUP_TIMER_CYCLES;
			cur.ostCount   <= 10'h000;
			cur.ostDone    <= 1'b0;
			cur.status     <= rst_pkg::STATUS_POR_VAL;
			cur.currentOsc <= rst_pkg::OSC_RESET;
			cur.rdData     <= 16'h0000;
			cur.sysRstN    <= 1'b0;
			cur.clkRel     <= 1'b0;
			cur.exec       <= 1'b0;
			cur.wdtEn      <= 1'b0;
			cur.pmSleep    <= 1'b0;
			cur.monEn      <= 1'b0;
			cur.clkSel     <= rst_pkg::OSC_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign regRdData              = cur.rdData;
	assign systemReset_n          = cur.sysRstN;
	assign clockReleased          = cur.clkRel;
	assign execEnable             = cur.exec;
	assign watchdogEnable         = cur.wdtEn;
	assign progmemSleepPower      = cur.pmSleep;
	assign clockFailMonitorEnable = cur.monEn;
	assign sysClkSelect           = cur.clkSel;

endmodule

// file: dv/rst_sequencer_sva.sv
// port assertions for the reset sequencer
`timescale 1ns/1ps

module rst_sequencer_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// reset sources and watchdog fuse
	input wire logic        masterClearPin_n,
	input wire logic        brownoutEvent,
	input wire logic        trapConflict,
	input wire logic        illegalOp,
	input wire logic        cfgMismatch,
	input wire logic        softResetInstr,
	input wire logic        watchdogTimeout,
	input wire logic        watchdogFuseEnable,
	// register port
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [15:0] regRdData,
	// system outputs
	input wire logic        systemReset_n,
	input wire logic        clockReleased,
	input wire logic        execEnable,
	input wire logic        watchdogEnable,
	input wire logic        progmemSleepPower,
	input wire logic        clockFailMonitorEnable
);
	wire anySource = trapConflict | illegalOp | cfgMismatch | softResetInstr
		| watchdogTimeout | brownoutEvent | !masterClearPin_n;
	wire statusRd = regRd && regAddr == 4'h0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_SRC_HOLD: assert property (anySource |=> !systemReset_n)
		else $error("system reset missed a source");
	AST_HOLD_MIN: assert property ($fell(systemReset_n) |-> !systemReset_n [*3])
		else $error("system reset released too early");
	AST_EXEC: assert property (execEnable |-> systemReset_n && clockReleased)
		else $error("execution without both releases");
	AST_CLOCK_FAIL_MONITOR: assert property (!systemReset_n |-> !clockFailMonitorEnable)
		else $error("clock monitor active during reset");
	AST_WDT_FUSE: assert property (watchdogFuseEnable |=> watchdogEnable)
		else $error("fuse did not force the watchdog");
	AST_UNIMPL: assert property (regRd |=> regRdData[13:11] == 3'h0)
		else $error("unimplemented bits read nonzero");
	AST_SOFT_FLAG: assert property (softResetInstr ##1 statusRd |=> regRdData[6])
		else $error("soft reset flag not set");
	AST_TRAP_FLAG: assert property (trapConflict ##1 statusRd |=> regRdData[15])
		else $error("trap flag not set");
	AST_PROGMEM_SLEEP_POWER: assert property (regWr && regAddr == 4'h0 |=>
		progmemSleepPower == $past(regWrData[8]))
		else $error("bias control does not follow bit 8");
	cover property ($rose(systemReset_n));
	cover property ($rose(execEnable));
	cover property (brownoutEvent ##1 !systemReset_n);
endmodule

// file: dv/rst_osc_model.sv
// oscillator and pll model facing the sequencer
`timescale 1ns/1ps

module rst_osc_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pll request
	input  wire logic pllEnable,
	// oscillator status
	output logic      oscTick,
	output logic      pllLocked
);
	logic [3:0] lockCnt;
	// crystal at half the system rate, so start-up spans two cycles a tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oscTick <= 1'b0;
			lockCnt <= 4'h0;
		end else begin
			oscTick <= !oscTick;
			lockCnt <= pllEnable ? lockCnt + 4'(lockCnt != 4'hF) : 4'h0;
		end
	end
	assign pllLocked = lockCnt == 4'hF;
endmodule

// file: dv/rst_sequencer_test.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps

module rst_sequencer_test;
	localparam int T_RST = 3;
	localparam int T_BOR = 23;
	localparam int T_POR = 28;
	typedef struct {logic [6:0] s; logic rd; logic [15:0] m; int lo;} rst_row_t;
	logic        clk, rst_n, deepSleepArm, wdtFuse, clkSw, regDis, regWr, regRd;
	logic        tss, oscSlow, pllEn, monFuse;
	logic        oscTick, pllLocked, systemReset_n, clockReleased, execEnable;
	logic        watchdogEnable, progmemSleepPower, clockFailMonitorEnable;
	logic [6:0]  src;
	logic [1:0]  psv;
	logic [2:0]  sysClkSelect;
	logic [3:0]  regAddr;
	logic [15:0] regWrData, regRdData, got;
	int          n_fail, tests_run, n;
	rst_row_t    rows[8] = '{'{7'h01, 1'b0, 16'h8000, T_RST}, '{7'h02, 1'b0, 16'h4000, T_RST},
		'{7'h04, 1'b0, 16'h0200, T_RST}, '{7'h08, 1'b0, 16'h0040, T_RST},
		'{7'h10, 1'b0, 16'h0010, T_RST}, '{7'h20, 1'b0, 16'h0002, T_RST},
		'{7'h20, 1'b1, 16'h0002, T_BOR}, '{7'h40, 1'b0, 16'h0080, T_RST}};

	rst_sequencer #(.POWERUP_TIMER_CYCLES(32'h14), .POR_CYCLES(32'h5), .RST_CYCLES(32'h3)) i_dut (
		.clk(clk), .rst_n(rst_n), .masterClearPin_n(!src[6]), .brownoutEvent(src[5]),
		.trapConflict(src[0]), .illegalOp(src[1]), .cfgMismatch(src[2]),
		.softResetInstr(src[3]), .watchdogTimeout(src[4]), .sleepInstr(psv[0]),
		.idleInstr(psv[1]), .deepSleepArm(deepSleepArm), .watchdogFuseEnable(wdtFuse),
		.clockSwitchEnable(clkSw), .cfgOscSelect(3'h5), .twoSpeedStartup(tss),
		.regulatorDisablePin(regDis), .clockFailMonitorFuse(monFuse), .oscTick(oscTick),
		.oscNeedsStartup(oscSlow), .pllEnable(pllEn), .pllLocked(pllLocked),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .systemReset_n(systemReset_n), .clockReleased(clockReleased),
		.execEnable(execEnable), .watchdogEnable(watchdogEnable),
		.progmemSleepPower(progmemSleepPower), .clockFailMonitorEnable(clockFailMonitorEnable),
		.sysClkSelect(sysClkSelect));
	rst_osc_model i_osc (.clk(clk), .rst_n(rst_n), .pllEnable(pllEn), .oscTick(oscTick),
		.pllLocked(pllLocked));

	task automatic summarize();
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
		@(posedge clk) regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
		@(posedge clk) regRd <= 1'b0;
		#1 got = regRdData;
	endtask
	// bounded wait on release (sel 0) or on execution (sel 1), counting cycles in n
	task automatic waitHigh(input logic sel);
		for (int i = 0; i < 4000 && !(sel ? execEnable : systemReset_n); i++) begin
			n++;
			@(posedge clk);
			#1;
		end
		if (!(sel ? execEnable : systemReset_n)) begin
			chk(16'h0000, 16'h0001);
			summarize();
		end
	endtask
	// source for one cycle, status read in the very next one
	task automatic pulse(input logic [6:0] s);
		@(posedge clk) src <= s;
		@(posedge clk) begin src <= 7'h00; regRd <= 1'b1; regAddr <= 4'h0; end
		@(posedge clk) regRd <= 1'b0;
		#1 got = regRdData;
		n = 1;
		waitHigh(1'b0);
	endtask
	task automatic strobe(input logic [1:0] p);
		@(posedge clk) psv <= p;
		@(posedge clk) psv <= 2'h0;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end

	initial begin
		// ****
		// power-on release, then each reset source
		// ****
		{rst_n, src, psv, deepSleepArm, wdtFuse, regDis, regWr, regRd} = '0;
		{clkSw, tss, pllEn, regAddr, regWrData, n_fail, tests_run, n} = '0;
		clkSw = 1'b1;
		oscSlow = 1'b1;
		monFuse = 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1 waitHigh(1'b0);
		chk(16'(n >= T_POR && n <= T_POR + 3), 16'h0001);
		chk({15'h0, execEnable}, 16'h0000);
		waitHigh(1'b1);
		chk(16'(n >= 2048 && n <= 2100), 16'h0001);
		rd(4'h0);
		chk(got, 16'h0003);
		chk({13'h0, sysClkSelect}, 16'h0005);
		foreach (rows[i]) begin
			wr(4'h0, 16'h0000);
			regDis <= rows[i].rd;
			pulse(rows[i].s);
			chk(got, rows[i].m);
			chk(16'(n >= rows[i].lo && n <= rows[i].lo + 2), 16'h0001);
		end
		// ****
		// power-save flags and software access
		// ****
		wr(4'h0, 16'h0010);
		deepSleepArm <= 1'b1;
		strobe(2'h1);
		rd(4'h0);
		chk(got, 16'h0408);
		wr(4'h0, 16'h0010);
		strobe(2'h2);
		rd(4'h0);
		chk(got, 16'h0004);
		wr(4'h0, 16'hFFFF);
		rd(4'h0);
		chk(got, 16'hC3FF);
		chk({13'h0, systemReset_n, watchdogEnable, progmemSleepPower}, 16'h0007);
		wr(4'h0, 16'h0000);
		rd(4'h7);
		chk({got[14:0], watchdogEnable}, 16'h0000);
		wdtFuse <= 1'b1;
		rd(4'h7);
		chk({15'h0, watchdogEnable}, 16'h0001);
		wdtFuse <= 1'b0;
		// ****
		// clock source after reset
		// ****
		wr(4'h1, 16'h2000);
		pulse(7'h08);
		chk({13'h0, sysClkSelect}, 16'h0002);
		pulse(7'h20);
		chk({13'h0, sysClkSelect}, 16'h0005);
		clkSw <= 1'b0;
		wr(4'h1, 16'h2000);
		pulse(7'h08);
		chk({13'h0, sysClkSelect}, 16'h0005);
		// ****
		// start-up options
		// ****
		chk({15'h0, clockFailMonitorEnable}, 16'h0001);
		monFuse <= 1'b0;
		tss <= 1'b1;
		pulse(7'h40);
		chk({10'h0, sysClkSelect, clockFailMonitorEnable, clockReleased, execEnable}, 16'h0003);
		repeat (2100) @(posedge clk);
		#1 chk({13'h0, sysClkSelect}, 16'h0005);
		tss <= 1'b0;
		oscSlow <= 1'b0;
		pllEn <= 1'b1;
		@(posedge clk);
		#1 n = 1;
		waitHigh(1'b1);
		chk(16'(n >= 16 && n <= 18), 16'h0001);
		// set beats a software clear in the same cycle
		@(posedge clk) begin regWr <= 1'b1; regAddr <= 4'h0; regWrData <= 16'h0000; psv <= 2'h2; end
		@(posedge clk) begin regWr <= 1'b0; psv <= 2'h0; end
		rd(4'h0);
		chk(got, 16'h0004);
		// ****
		// second power-on in mid-run
		// ****
		wr(4'h0, 16'h8000);
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) rst_n <= 1'b1;
		#1 n = 0;
		waitHigh(1'b0);
		chk(16'(n >= T_POR && n <= T_POR + 3), 16'h0001);
		rd(4'h0);
		chk(got, 16'h0003);
		summarize();
	end
endmodule

bind rst_sequencer rst_sequencer_sva i_sva (.*);
